//--- design/port_f_ctrl.sv
// Purpose: pin function select, open-drain, pull-up and input enable for port F
// Assumes: AXI4-Lite slave, one write and one read in flight at most
// Notes:   pin inputs pass two flops; stop mode input is on the clock domain
// Operation
// - function select two bit 5 routes pin 5 to external interrupt seven.
// - function select two bit 4 routes pin 4 to external interrupt six.
// - function select two bits 31..6 and 3..0 read zero.
// - function select three bit 5 routes pin 5 to timer 5 capture 1.
// - function select three bit 4 routes pin 4 to timer 5 capture 0.
// - function select three bit 0 drives pin 0 from timer 6; others zero.
// - open-drain bit set gives open-drain, clear push-pull; bits 31..8 zero.
// - pull-up bit set enables that pin pull-up; bits 31..8 read zero.
// - pull-up register resets to one in bit 0 only.
// - input enable exists for pins 7..1; bit 0 reads zero.
// - input enable clear blocks the pin input, set passes it.
// - outside stop, enabled interrupt pins feed interrupts whatever the select.
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
module port_f_ctrl
  import port_f_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
) (
  input  wire logic              I_CLOCK,
  input  wire logic              I_RESET_N,
  // register bus
  input  wire logic [ADDR_W-1:0] I_AWADDR,
  input  wire logic              I_AWVALID,
  output logic                   O_AWREADY,
  input  wire logic [31:0]       I_WDATA,
  input  wire logic [3:0]        I_WSTRB,
  input  wire logic              I_WVALID,
  output logic                   O_WREADY,
  output logic [1:0]             O_BRESP,
  output logic                   O_BVALID,
  input  wire logic              I_BREADY,
  input  wire logic [ADDR_W-1:0] I_ARADDR,
  input  wire logic              I_ARVALID,
  output logic                   O_ARREADY,
  output logic [31:0]            O_RDATA,
  output logic [1:0]             O_RRESP,
  output logic                   O_RVALID,
  input  wire logic              I_RREADY,
  // pads
  input  wire logic [7:0]        I_PIN_IN,
  output logic [7:0]             O_PIN_OUT,
  output logic [7:0]             O_PIN_OE,
  output logic [7:0]             O_PULLUP_EN,
  // peripheral side
  input  wire logic              I_STOP_MODE,
  input  wire logic              I_TIMER6_OUTPUT,
  output logic                   O_EXTERNAL_INTERRUPT_SEVEN,
  output logic                   O_EXTERNAL_INTERRUPT_SIX,
  output logic                   O_TIMER5_CAPTURE_IN1,
  output logic                   O_TIMER5_CAPTURE_IN0
);

  initial begin
    if (ADDR_W < 6 || ADDR_W > 12) begin
      $error("port_f_ctrl: ADDR_W must lie between 6 and 12");
    end
  end

  // reset release and pin synchronisers
  logic             rst_n;
  logic [7:0]       pin_sync;

  // registers
  logic [7:0]       data_out;
  logic [7:0]       out_enable;
  logic [7:0]       pin5_pin4_irq_sel;
  logic [7:0]       timer_sel;
  logic [7:0]       open_drain_bits;
  logic [7:0]       pullup_bits;
  logic [7:0]       input_enable_bits;

  // bus state
  logic [11:0]      aw_addr;
  logic             aw_held;
  logic [7:0]       w_data;
  logic             w_low_lane;
  logic             w_held;
  logic             do_write;
  logic             wr_hit;
  logic             do_read;
  logic             rd_hit;
  logic [7:0]       rd_byte;
  logic [11:0]      ar_full;

  // pin data paths
  logic [7:0]       pin_gated;
  logic [7:0]       drive_value;
  logic [7:0]       drive_enable;

  // reset: asserted at once, released through two flops
  port_f_sync #(
    .WIDTH (1)
  ) u_reset_sync (
    .i_clk   (I_CLOCK),
    .i_rst_n (I_RESET_N),
    .i_async (1'b1),
    .o_sync  (rst_n)
  );

  // pad inputs come from outside the clock domain
  port_f_sync #(
    .WIDTH (8)
  ) u_pin_sync (
    .i_clk   (I_CLOCK),
    .i_rst_n (rst_n),
    .i_async (I_PIN_IN),
    .o_sync  (pin_sync)
  );

  // ---------------- bus slave: write side

  // address and data may come in either order; each is held until used
  assign O_AWREADY = !aw_held && !O_BVALID;
  assign O_WREADY  = !w_held && !O_BVALID;
  assign do_write  = aw_held && w_held && !O_BVALID;

  // write address capture
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      aw_addr <= 12'h000;
      aw_held <= 1'b0;
    end else if (I_AWVALID && O_AWREADY) begin
      aw_addr <= 12'(I_AWADDR);
      aw_held <= 1'b1;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  // write data capture, low lane only carries register bits
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      w_data     <= 8'h00;
      w_low_lane <= 1'b0;
      w_held     <= 1'b0;
    end else if (I_WVALID && O_WREADY) begin
      w_data     <= I_WDATA[7:0];
      w_low_lane <= I_WSTRB[0];
      w_held     <= 1'b1;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // decode of the held write address
  always_comb begin
    if (aw_addr[11:2] == OFS_DATA[11:2]) begin
      wr_hit = 1'b1;
    end else if (aw_addr[11:2] == OFS_OUT_ENABLE[11:2]) begin
      wr_hit = 1'b1;
    end else if (aw_addr[11:2] == OFS_FUNC_SEL_TWO[11:2]) begin
      wr_hit = 1'b1;
    end else if (aw_addr[11:2] == OFS_FUNC_SEL_THR[11:2]) begin
      wr_hit = 1'b1;
    end else if (aw_addr[11:2] == OFS_OPEN_DRAIN[11:2]) begin
      wr_hit = 1'b1;
    end else if (aw_addr[11:2] == OFS_PULLUP[11:2]) begin
      wr_hit = 1'b1;
    end else if (aw_addr[11:2] == OFS_INPUT_ENABLE[11:2]) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  // write response, unmapped words answer with an error
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      O_BVALID <= 1'b0;
      O_BRESP  <= RESP_OKAY;
    end else if (do_write) begin
      O_BVALID <= 1'b1;
      O_BRESP  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (I_BREADY) begin
      O_BVALID <= 1'b0;
    end
  end

  // ---------------- register file

  // port data and output enable
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      data_out   <= RST_DATA;
      out_enable <= RST_OUT_ENABLE;
    end else if (do_write && w_low_lane) begin
      if (aw_addr[11:2] == OFS_DATA[11:2]) begin
        data_out <= w_data;
      end
      if (aw_addr[11:2] == OFS_OUT_ENABLE[11:2]) begin
        out_enable <= w_data;
      end
    end
  end

  // function selects keep only their implemented bits
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      pin5_pin4_irq_sel <= RST_FUNC_SEL_TWO;
      timer_sel         <= RST_FUNC_SEL_THR;
    end else if (do_write && w_low_lane) begin
      if (aw_addr[11:2] == OFS_FUNC_SEL_TWO[11:2]) begin
        pin5_pin4_irq_sel <= w_data & MASK_FUNC_SEL_TWO;
      end
      if (aw_addr[11:2] == OFS_FUNC_SEL_THR[11:2]) begin
        timer_sel <= w_data & MASK_FUNC_SEL_THR;
      end
    end
  end

  // pad controls
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      open_drain_bits   <= RST_OPEN_DRAIN;
      pullup_bits       <= RST_PULLUP;
      input_enable_bits <= RST_INPUT_ENABLE;
    end else if (do_write && w_low_lane) begin
      if (aw_addr[11:2] == OFS_OPEN_DRAIN[11:2]) begin
        open_drain_bits <= w_data;
      end
      if (aw_addr[11:2] == OFS_PULLUP[11:2]) begin
        pullup_bits <= w_data;
      end
      if (aw_addr[11:2] == OFS_INPUT_ENABLE[11:2]) begin
        input_enable_bits <= w_data & MASK_INPUT_ENABLE;
      end
    end
  end

  // ---------------- bus slave: read side

  assign O_ARREADY = !O_RVALID;
  assign do_read   = I_ARVALID && O_ARREADY;
  assign ar_full   = 12'(I_ARADDR);

  // read mux; upper bits always zero
  always_comb begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    if (ar_full[11:2] == OFS_DATA[11:2]) begin
      rd_byte = pin_gated;
    end else if (ar_full[11:2] == OFS_OUT_ENABLE[11:2]) begin
      rd_byte = out_enable;
    end else if (ar_full[11:2] == OFS_FUNC_SEL_TWO[11:2]) begin
      rd_byte = pin5_pin4_irq_sel;
    end else if (ar_full[11:2] == OFS_FUNC_SEL_THR[11:2]) begin
      rd_byte = timer_sel;
    end else if (ar_full[11:2] == OFS_OPEN_DRAIN[11:2]) begin
      rd_byte = open_drain_bits;
    end else if (ar_full[11:2] == OFS_PULLUP[11:2]) begin
      rd_byte = pullup_bits;
    end else if (ar_full[11:2] == OFS_INPUT_ENABLE[11:2]) begin
      rd_byte = input_enable_bits;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      O_RVALID <= 1'b0;
      O_RDATA  <= 32'h0000_0000;
      O_RRESP  <= RESP_OKAY;
    end else if (do_read) begin
      O_RVALID <= 1'b1;
      O_RDATA  <= {24'h00_0000, rd_byte};
      O_RRESP  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (I_RREADY) begin
      O_RVALID <= 1'b0;
    end
  end

  // ---------------- pin logic

  // per pin input gating and driver shaping
  generate
    for (genvar p = 0; p < 8; p++) begin : g_pin
      logic out_val;
      logic out_en;
      // driven pins read back their latch, others the gated pad
      assign pin_gated[p] = out_enable[p] ? data_out[p]
                          : (pin_sync[p] & input_enable_bits[p]);
      if (p == BIT_PIN0) begin : g_timer_out
        // timer 6 takes over the pad value when selected
        assign out_val = timer_sel[BIT_PIN0] ? I_TIMER6_OUTPUT : data_out[p];
        assign out_en  = timer_sel[BIT_PIN0] | out_enable[p];
      end else begin : g_plain_out
        assign out_val = data_out[p];
        assign out_en  = out_enable[p];
      end
      // open drain drives only lows, push-pull drives both
      assign drive_value[p]  = out_val & ~open_drain_bits[p];
      assign drive_enable[p] = out_en & (~open_drain_bits[p] | ~out_val);
    end
  endgenerate

  // pad outputs from flops
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      O_PIN_OUT   <= 8'h00;
      O_PIN_OE    <= 8'h00;
      O_PULLUP_EN <= RST_PULLUP;
    end else begin
      O_PIN_OUT   <= drive_value;
      O_PIN_OE    <= drive_enable;
      O_PULLUP_EN <= pullup_bits;
    end
  end

  // interrupt and capture routing; in stop only selected pins pass
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      O_EXTERNAL_INTERRUPT_SEVEN <= 1'b0;
      O_EXTERNAL_INTERRUPT_SIX   <= 1'b0;
      O_TIMER5_CAPTURE_IN1       <= 1'b0;
      O_TIMER5_CAPTURE_IN0       <= 1'b0;
    end else begin
      O_EXTERNAL_INTERRUPT_SEVEN <= pin_sync[BIT_PIN5] & input_enable_bits[BIT_PIN5]
        & (~I_STOP_MODE | pin5_pin4_irq_sel[BIT_PIN5]);
      O_EXTERNAL_INTERRUPT_SIX   <= pin_sync[BIT_PIN4] & input_enable_bits[BIT_PIN4]
        & (~I_STOP_MODE | pin5_pin4_irq_sel[BIT_PIN4]);
      O_TIMER5_CAPTURE_IN1       <= pin_sync[BIT_PIN5] & input_enable_bits[BIT_PIN5]
        & timer_sel[BIT_PIN5];
      O_TIMER5_CAPTURE_IN0       <= pin_sync[BIT_PIN4] & input_enable_bits[BIT_PIN4]
        & timer_sel[BIT_PIN4];
    end
  end

endmodule

//--- design/port_f_pkg.sv
// Purpose: shared constants for the port F pin function and pad control block
// Assumes: 32-bit register words, each register on one aligned word address
// Notes:   masks give the implemented bits; every other bit reads zero
package port_f_pkg;

  // register byte offsets
  localparam logic [11:0] OFS_DATA         = 12'h000;
  localparam logic [11:0] OFS_OUT_ENABLE   = 12'h004;
  localparam logic [11:0] OFS_FUNC_SEL_TWO = 12'h00C;
  localparam logic [11:0] OFS_FUNC_SEL_THR = 12'h010;
  localparam logic [11:0] OFS_OPEN_DRAIN   = 12'h028;
  localparam logic [11:0] OFS_PULLUP       = 12'h02C;
  localparam logic [11:0] OFS_INPUT_ENABLE = 12'h038;

  // implemented bits per register
  localparam logic [7:0] MASK_FULL         = 8'hFF;
  localparam logic [7:0] MASK_FUNC_SEL_TWO = 8'h30;
  localparam logic [7:0] MASK_FUNC_SEL_THR = 8'h31;
  localparam logic [7:0] MASK_INPUT_ENABLE = 8'hFE;

  // field positions
  localparam int unsigned BIT_PIN0 = 0;
  localparam int unsigned BIT_PIN4 = 4;
  localparam int unsigned BIT_PIN5 = 5;

  // values after reset
  localparam logic [7:0] RST_DATA         = 8'h00;
  localparam logic [7:0] RST_OUT_ENABLE   = 8'h00;
  localparam logic [7:0] RST_FUNC_SEL_TWO = 8'h00;
  localparam logic [7:0] RST_FUNC_SEL_THR = 8'h00;
  localparam logic [7:0] RST_OPEN_DRAIN   = 8'h00;
  localparam logic [7:0] RST_PULLUP       = 8'h01;
  localparam logic [7:0] RST_INPUT_ENABLE = 8'h00;

  // bus response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // synchroniser depth in cycles
  localparam int unsigned SYNC_STAGES = 2;

endpackage

//--- design/port_f_sync.sv
// Purpose: two-flop synchroniser for levels entering the clock domain
// Assumes: reset is asynchronous, active low, and loads zero
// Notes:   the first stage feeds only the second stage
module port_f_sync
  import port_f_pkg::*;
#(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta;

  initial begin
    if (WIDTH < 1) begin
      $error("port_f_sync: WIDTH must be at least one");
    end
  end

  // two stages, zero under reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta   <= '0;
      o_sync <= '0;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end

endmodule

//--- dv/port_f_ctrl_props.sv
// Purpose: concurrent checks on the port F control ports
// Assumes: one clock, reset low and asynchronous
// Notes:   read masks keyed on the address of the read in flight
module port_f_ctrl_props
  import port_f_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
) (
  input wire logic              I_CLOCK,
  input wire logic              I_RESET_N,
  input wire logic [1:0]        O_BRESP,
  input wire logic              O_BVALID,
  input wire logic              I_BREADY,
  input wire logic [ADDR_W-1:0] I_ARADDR,
  input wire logic              I_ARVALID,
  input wire logic              O_ARREADY,
  input wire logic [31:0]       O_RDATA,
  input wire logic              O_RVALID,
  input wire logic [7:0]        I_PIN_IN,
  input wire logic [7:0]        O_PULLUP_EN,
  input wire logic              O_EXTERNAL_INTERRUPT_SEVEN
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [ADDR_W-1:0] rd_addr;
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RESET_N);
  // address of the read in flight
  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) rd_addr <= '0;
    else if (I_ARVALID && O_ARREADY) rd_addr <= I_ARADDR;
  end
  sequence s_rd(logic [11:0] ofs);
    O_RVALID && rd_addr[ADDR_W-1:2] == ofs[ADDR_W-1:2];
  endsequence
  sequence s_ar;
    I_ARVALID && O_ARREADY;
  endsequence
  property p_hi_zero;
    O_RVALID |-> O_RDATA[31:8] == 24'h0;
  endproperty
  a_hi_zero: assert property (p_hi_zero)
    else $error("read data above bit 7 not zero");
  property p_sel2;
    s_rd(OFS_FUNC_SEL_TWO) |-> O_RDATA[7:0] == (O_RDATA[7:0] & MASK_FUNC_SEL_TWO);
  endproperty
  a_sel2: assert property (p_sel2)
    else $error("select two spare bit set");
  property p_sel3;
    s_rd(OFS_FUNC_SEL_THR) |-> O_RDATA[7:0] == (O_RDATA[7:0] & MASK_FUNC_SEL_THR);
  endproperty
  a_sel3: assert property (p_sel3)
    else $error("select three spare bit set");
  property p_ie;
    s_rd(OFS_INPUT_ENABLE) |-> O_RDATA[0] == 1'h0;
  endproperty
  a_ie: assert property (p_ie)
    else $error("input enable bit 0 set");
  property p_pull_rst;
    disable iff (1'h0) $rose(I_RESET_N) |-> O_PULLUP_EN == RST_PULLUP;
  endproperty
  a_pull_rst: assert property (p_pull_rst)
    else $error("pull-up enables wrong in reset");
  property p_external_interrupt_seven;
    O_EXTERNAL_INTERRUPT_SEVEN |-> $past(I_PIN_IN[5], 3);
  endproperty
  a_external_interrupt_seven: assert property (p_external_interrupt_seven)
    else $error("interrupt seven without pin 5 high");
  property p_bhold;
    O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP);
  endproperty
  a_bhold: assert property (p_bhold)
    else $error("write response dropped early");
  property p_rd_resp;
    s_ar |=> O_RVALID;
  endproperty
  a_rd_resp: assert property (p_rd_resp)
    else $error("read answer late");
endmodule

bind port_f_ctrl port_f_ctrl_props #(.ADDR_W(ADDR_W)) i_props (
  .I_CLOCK(I_CLOCK), .I_RESET_N(I_RESET_N), .O_BRESP(O_BRESP), .O_BVALID(O_BVALID),
  .I_BREADY(I_BREADY), .I_ARADDR(I_ARADDR), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY),
  .O_RDATA(O_RDATA), .O_RVALID(O_RVALID), .I_PIN_IN(I_PIN_IN), .O_PULLUP_EN(O_PULLUP_EN),
  .O_EXTERNAL_INTERRUPT_SEVEN(O_EXTERNAL_INTERRUPT_SEVEN)
);

//--- dv/port_f_pads.sv
// Purpose: external circuitry on the port F pads
// Assumes: a pad with no driver and no pull-up floats
// Notes:   a floating pad toggles every cycle so no level is guessed
module port_f_pads (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_out,
  input  wire logic [7:0] i_oe,
  input  wire logic [7:0] i_pullup,
  input  wire logic [7:0] i_ext_val,
  input  wire logic [7:0] i_ext_en,
  output logic      [7:0] o_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic float_pat = 1'h0;
  // changing level for an undriven pad
  always @(posedge i_clk) float_pat <= ~float_pat;
  // pad level from every driver
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (i_oe[i]) o_level[i] = i_out[i];
      else if (i_ext_en[i]) o_level[i] = i_ext_val[i];
      else if (i_pullup[i]) o_level[i] = 1'h1;
      else o_level[i] = float_pat;
    end
  end
endmodule

//--- dv/tb_top.sv
// Purpose: self-checking bench for the port F control block
// Assumes: register bus master in the bench, pads from the pad model
// Notes:   bus results are noted in queues and matched by a watcher
module tb_top
  import port_f_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, stop = 0, tmr6 = 0;
  logic [3:0]  wstrb = 4'hF;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [7:0]  ext_val = '0, ext_en = '0, pin_in, pin_out, pin_oe, pull;
  logic        awready, wready, bvalid, arready, rvalid, external_interrupt_seven, external_interrupt_six, cap1, cap0;
  logic [1:0]  bresp, rresp, wq[$];
  logic [33:0] rq[$];
  int          num_errors = 0, checked = 0, cyc = 0;
  logic [11:0] ofs[5] = '{OFS_FUNC_SEL_TWO, OFS_FUNC_SEL_THR, OFS_OPEN_DRAIN, OFS_PULLUP,
                          OFS_INPUT_ENABLE};
  logic [7:0]  msk[5] = '{MASK_FUNC_SEL_TWO, MASK_FUNC_SEL_THR, MASK_FULL, MASK_FULL,
                          MASK_INPUT_ENABLE};
  logic [7:0]  rst[5] = '{RST_FUNC_SEL_TWO, RST_FUNC_SEL_THR, RST_OPEN_DRAIN, RST_PULLUP,
                          RST_INPUT_ENABLE};
  logic [11:0] bad[2] = '{12'h008, 12'h03C};

  // 100 MHz clock
  always #5 clk = ~clk;

  port_f_ctrl #(.ADDR_W(12)) i_dut (
    .I_CLOCK(clk), .I_RESET_N(rst_n), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
    .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid),
    .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
    .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
    .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_PIN_IN(pin_in),
    .O_PIN_OUT(pin_out), .O_PIN_OE(pin_oe), .O_PULLUP_EN(pull), .I_STOP_MODE(stop),
    .I_TIMER6_OUTPUT(tmr6), .O_EXTERNAL_INTERRUPT_SEVEN(external_interrupt_seven),
    .O_EXTERNAL_INTERRUPT_SIX(external_interrupt_six), .O_TIMER5_CAPTURE_IN1(cap1), .O_TIMER5_CAPTURE_IN0(cap0)
  );

  port_f_pads i_pads (
    .i_clk(clk), .i_out(pin_out), .i_oe(pin_oe), .i_pullup(pull),
    .i_ext_val(ext_val), .i_ext_en(ext_en), .o_level(pin_in)
  );

  task automatic stop_test();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // write response against its note
  task automatic cmp_resp(input logic [1:0] exp, input logic [1:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected write response: expected %h seen %h", exp, got);
    end
  endtask

  // read response code and data against its note
  task automatic cmp_read(input logic [33:0] exp, input logic [33:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected read result: expected %h seen %h", exp, got);
    end
  endtask

  // pad and peripheral side levels
  task automatic cmp_pin(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic do_reset();
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw, w;
    aw = 0;
    w = 0;
    wq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    while (!(aw && w)) begin
      @(posedge clk);
      aw = aw | awready;
      w = w | wready;
      awvalid <= !aw;
      wvalid <= !w;
    end
    repeat ($urandom_range(2)) @(posedge clk);
    bready <= 1'h1;
    do @(posedge clk); while (!bvalid);
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    rq.push_back(e);
    araddr <= a;
    arvalid <= 1'h1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'h0;
    repeat ($urandom_range(2)) @(posedge clk);
    rready <= 1'h1;
    do @(posedge clk); while (!rvalid);
    rready <= 1'h0;
  endtask

  // oldest note against each bus answer
  always @(posedge clk) begin
    if (bvalid && bready) cmp_resp(wq.pop_front(), bresp);
    if (rvalid && rready) cmp_read(rq.pop_front(), {rresp, rdata});
  end

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      stop_test();
    end
  end

  // main sequence
  initial begin
    logic [31:0] v;
    logic [7:0]  e;
    v = $urandom(32'h1964);
    do_reset();
    // random words in, only live bits read back
    foreach (ofs[i]) begin
      v = $urandom();
      wr(ofs[i], v, RESP_OKAY);
      rd(ofs[i], {RESP_OKAY, 24'h0, v[7:0] & msk[i]});
      if (ofs[i] == OFS_PULLUP) cmp_pin("pull-up pins", v[7:0], pull);
    end
    foreach (bad[i]) begin
      wr(bad[i], $urandom(), RESP_SLVERR);
      rd(bad[i], {RESP_SLVERR, 32'h0});
    end
    // reset in mid-run, values after reset
    do_reset();
    foreach (ofs[i]) rd(ofs[i], {RESP_OKAY, 24'h0, rst[i]});
    cmp_pin("pull-up pins", RST_PULLUP, pull);
    // low lane strobe clear: answered but nothing written
    wstrb <= 4'h0;
    wr(OFS_PULLUP, 32'hFF, RESP_OKAY);
    wstrb <= 4'hF;
    rd(OFS_PULLUP, {RESP_OKAY, 24'h0, RST_PULLUP});
    // all pins from outside, every mix of enable, both selects and stop
    ext_en <= 8'hFF;
    for (int c = 0; c < 16; c++) begin
      v = $urandom();
      wr(OFS_INPUT_ENABLE, c[0] ? 32'hFE : 32'h0, RESP_OKAY);
      wr(OFS_FUNC_SEL_TWO, c[1] ? 32'h30 : 32'h0, RESP_OKAY);
      wr(OFS_FUNC_SEL_THR, c[3] ? 32'h30 : 32'h0, RESP_OKAY);
      stop <= c[2];
      ext_val <= v[7:0];
      repeat (4) @(posedge clk);
      cmp_pin("interrupt seven", v[5] & c[0] & (!c[2] | c[1]), external_interrupt_seven);
      cmp_pin("interrupt six", v[4] & c[0] & (!c[2] | c[1]), external_interrupt_six);
      cmp_pin("capture one", v[5] & c[0] & c[3], cap1);
      cmp_pin("capture zero", v[4] & c[0] & c[3], cap0);
      rd(OFS_DATA, {RESP_OKAY, 24'h0, v[7:0] & (c[0] ? 8'hFE : 8'h00)});
    end
    // pad drive: open drain low nibble, pin 0 from the timer
    ext_en <= 8'h00;
    wr(OFS_DATA, 32'hA5, RESP_OKAY);
    wr(OFS_OUT_ENABLE, 32'hFF, RESP_OKAY);
    wr(OFS_OPEN_DRAIN, 32'h0F, RESP_OKAY);
    rd(OFS_DATA, {RESP_OKAY, 24'h0, 8'hA5});
    rd(OFS_OUT_ENABLE, {RESP_OKAY, 24'h0, 8'hFF});
    for (int t = 0; t < 4; t++) begin
      wr(OFS_FUNC_SEL_THR, {31'h0, t[0]}, RESP_OKAY);
      tmr6 <= t[1];
      repeat (2) @(posedge clk);
      e = {7'h52, t[0] ? t[1] : 1'h1};
      cmp_pin("pad enable", 8'(~(e & 8'h0F)), pin_oe);
      cmp_pin("pad value", e & 8'hF0, pin_out);
    end
    stop_test();
  end
endmodule
